// ### hdl/dmac_chain.v
// DMA channel address registers, descriptor chaining engine and data FIFO.
// Assumes an APB master on pclk, a local memory read port that answers one
// request at a time, and a PCI-side sink with valid/ready handshake.
//
// Behaviour
// - Four memory start address registers at 0x3C/0x48/0xA8/0xB4, reset zero.
// - Memory start address stays fixed; advancing address kept in readable register.
// - Four PCI start address registers at 0x40/0x4C/0xAC/0xB8, reset zero.
// - PCI start address stays fixed; advancing PCI address kept readable.
// - Four link pointer registers at 0xBC/0xC0/0xC4/0xC8, reset zero.
// - Each descriptor is four contiguous words; exactly four are read.
// - A zero link pointer ends the chain; nothing more is fetched.
// - Descriptors fetched by hardware alone; pointer fixed during its transfer.
// - Descriptors are followed wherever they lie, adjacent or not.
// - Per-channel chaining enable, channel 1 at bit 8 to channel 4 at 11.
// - Chaining disabled: transfer ends after the register-held structure.
`timescale 1ns/10ps
`include "dmac_defines.vh"

// ==========================================================
// Synchronous FIFO
module dmac_fifo #(
   parameter WIDTH = 64,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             pclk,
   input  wire             presetn,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge pclk) begin
      if (push)
         mem_r[wp_r] <= in_data;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         if (pop)
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // dmac_fifo

// ==========================================================
// Top: register file, chaining engine, output stage
module dmac_chain #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW    = 3
) (
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Local memory read port
   output reg         mem_rd,
   output reg  [31:0] mem_addr,
   input  wire        mem_rvalid,
   input  wire [31:0] mem_rdata,
   // PCI side data stream
   output reg         pci_valid,
   input  wire        pci_ready,
   output reg  [31:0] pci_addr,
   output reg  [31:0] pci_data
);
   localparam S_IDLE = 3'd0;
   localparam S_LOAD = 3'd1;
   localparam S_RUN  = 3'd2;
   localparam S_END  = 3'd3;
   localparam S_DESC = 3'd4;

   localparam K_MEM  = 3'd0;
   localparam K_PCI  = 3'd1;
   localparam K_LINK = 3'd2;
   localparam K_CNT  = 3'd3;
   localparam K_MISC = 3'd4;

   // ==========================================================
   // Channel registers
   reg [31:0] mem_start_r [0:3];
   reg [31:0] pci_start_r [0:3];
   reg [31:0] link_r      [0:3];
   reg [31:0] count_r     [0:3];
   reg [3:0]  chain_en_r;
   reg [3:0]  go_r;
   reg [3:0]  done_r;
   reg [2:0]  state_r;
   reg [1:0]  ch_r;
   reg [31:0] cur_mem_r;
   reg [31:0] cur_pci_r;
   reg [31:0] words_r;
   reg [2:0]  didx_r;
   reg        pend_r;
   integer    i;

   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [63:0] fifo_out_data;
   wire        fifo_push;
   wire        fifo_pop;
   wire        apb_acc;
   wire        apb_wr;
   wire        apb_rd;
   wire [5:0]  wdec;
   reg  [3:0]  go_pick;

   // Address decode: {hit, kind, channel}
   function [5:0] dec;
      input [7:0] a;
      begin
         case (a)
            `DMAC_OFF_MEM_START_CH1: dec = {1'b1, K_MEM, 2'd0};
            `DMAC_OFF_MEM_START_CH2: dec = {1'b1, K_MEM, 2'd1};
            `DMAC_OFF_MEM_START_CH3: dec = {1'b1, K_MEM, 2'd2};
            `DMAC_OFF_MEM_START_CH4: dec = {1'b1, K_MEM, 2'd3};
            `DMAC_OFF_PCI_START_CH1: dec = {1'b1, K_PCI, 2'd0};
            `DMAC_OFF_PCI_START_CH2: dec = {1'b1, K_PCI, 2'd1};
            `DMAC_OFF_PCI_START_CH3: dec = {1'b1, K_PCI, 2'd2};
            `DMAC_OFF_PCI_START_CH4: dec = {1'b1, K_PCI, 2'd3};
            `DMAC_OFF_LINK_CH1:      dec = {1'b1, K_LINK, 2'd0};
            `DMAC_OFF_LINK_CH2:      dec = {1'b1, K_LINK, 2'd1};
            `DMAC_OFF_LINK_CH3:      dec = {1'b1, K_LINK, 2'd2};
            `DMAC_OFF_LINK_CH4:      dec = {1'b1, K_LINK, 2'd3};
            `DMAC_OFF_COUNT_CH1:     dec = {1'b1, K_CNT, 2'd0};
            `DMAC_OFF_COUNT_CH2:     dec = {1'b1, K_CNT, 2'd1};
            `DMAC_OFF_COUNT_CH3:     dec = {1'b1, K_CNT, 2'd2};
            `DMAC_OFF_COUNT_CH4:     dec = {1'b1, K_CNT, 2'd3};
            `DMAC_OFF_WORDS_LEFT:    dec = {1'b1, K_MISC, 2'd0};
            `DMAC_OFF_CUR_MEM:       dec = {1'b1, K_MISC, 2'd1};
            `DMAC_OFF_CUR_PCI:       dec = {1'b1, K_MISC, 2'd2};
            `DMAC_OFF_ARB:           dec = {1'b1, K_MISC, 2'd3};
            `DMAC_OFF_START:         dec = {1'b1, 3'd5, 2'd0};
            `DMAC_OFF_STATUS:        dec = {1'b1, 3'd5, 2'd1};
            default:                 dec = 6'h00;
         endcase
      end
   endfunction

   // ==========================================================
   // APB slave: one wait state, answer registered
   assign apb_acc = psel & penable & pready;
   assign apb_wr  = apb_acc & pwrite & wdec[5];
   assign apb_rd  = psel & penable & ~pready & ~pwrite;
   assign wdec    = dec(paddr);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `DMAC_REG_RESET;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~wdec[5];
         if (apb_rd) begin
            case (wdec[5] ? wdec[4:2] : 3'd7)
               K_MEM:   prdata <= mem_start_r[wdec[1:0]];
               K_PCI:   prdata <= pci_start_r[wdec[1:0]];
               K_LINK:  prdata <= link_r[wdec[1:0]];
               K_CNT:   prdata <= count_r[wdec[1:0]];
               K_MISC: begin
                  case (wdec[1:0])
                     2'd0:    prdata <= words_r;
                     2'd1:    prdata <= cur_mem_r;
                     2'd2:    prdata <= cur_pci_r;
                     default: prdata <= {20'h00000, chain_en_r, 8'h00};
                  endcase
               end
               3'd5:    prdata <= wdec[1:0] == 2'd0 ? {28'h0000000, go_r} :
                                  {21'h000000, ch_r, state_r == S_IDLE ? 1'b0 : 1'b1,
                                   done_r, go_r};
               default: prdata <= `DMAC_REG_RESET;
            endcase
         end else if (apb_acc) begin
            prdata <= `DMAC_REG_RESET;
         end
      end
   end

   // ==========================================================
   // Engine
   always @* begin
      go_pick = 4'h0;
      if (go_r[0])
         go_pick = 4'h1;
      else if (go_r[1])
         go_pick = 4'h2;
      else if (go_r[2])
         go_pick = 4'h4;
      else if (go_r[3])
         go_pick = 4'h8;
   end

   // The read is issued only when the FIFO has room and just one is in
   // flight, so the returning word always fits.
   assign fifo_push = (state_r == S_RUN) & pend_r & mem_rvalid;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 4; i = i + 1) begin
            mem_start_r[i] <= `DMAC_REG_RESET;
            pci_start_r[i] <= `DMAC_REG_RESET;
            link_r[i]      <= `DMAC_REG_RESET;
            count_r[i]     <= `DMAC_REG_RESET;
         end
         chain_en_r <= 4'h0;
         go_r       <= 4'h0;
         done_r     <= 4'h0;
         state_r    <= S_IDLE;
         ch_r       <= 2'd0;
         cur_mem_r  <= `DMAC_REG_RESET;
         cur_pci_r  <= `DMAC_REG_RESET;
         words_r    <= `DMAC_REG_RESET;
         didx_r     <= 3'd0;
         pend_r     <= 1'b0;
         mem_rd     <= 1'b0;
         mem_addr   <= `DMAC_REG_RESET;
      end else begin
         // Software writes first; engine updates below take priority
         if (apb_wr) begin
            case (wdec[4:2])
               K_MEM:   mem_start_r[wdec[1:0]] <= pwdata;
               K_PCI:   pci_start_r[wdec[1:0]] <= pwdata;
               K_LINK:  link_r[wdec[1:0]]      <= pwdata;
               K_CNT:   count_r[wdec[1:0]]     <= pwdata;
               K_MISC:
                  if (wdec[1:0] == 2'd3)
                     chain_en_r <= pwdata[`DMAC_CHAIN_MSB:`DMAC_CHAIN_LSB];
               3'd5:
                  if (wdec[1:0] == 2'd0)
                     go_r <= go_r | pwdata[3:0];
                  else
                     done_r <= done_r & ~pwdata[7:4];
               default: ;
            endcase
         end
         if (mem_rvalid)
            mem_rd <= 1'b0;
         case (state_r)
            S_IDLE:
               if (go_pick != 4'h0) begin
                  ch_r    <= {go_pick[3] | go_pick[2], go_pick[3] | go_pick[1]};
                  state_r <= S_LOAD;
               end
            S_LOAD: begin
               // Start registers stay as written; only the copies advance
               cur_mem_r <= mem_start_r[ch_r];
               cur_pci_r <= pci_start_r[ch_r];
               words_r   <= count_r[ch_r];
               state_r   <= S_RUN;
            end
            S_RUN:
               if (pend_r) begin
                  if (mem_rvalid) begin
                     pend_r    <= 1'b0;
                     cur_mem_r <= cur_mem_r + `DMAC_WORD_BYTES;
                     cur_pci_r <= cur_pci_r + `DMAC_WORD_BYTES;
                     words_r   <= words_r - 32'h0000_0001;
                  end
               end else if (words_r == 32'h0000_0000) begin
                  state_r <= S_END;
               end else if (fifo_in_ready) begin
                  pend_r   <= 1'b1;
                  mem_rd   <= 1'b1;
                  mem_addr <= cur_mem_r;
               end
            S_END:
               if (chain_en_r[ch_r] && link_r[ch_r] != 32'h0000_0000) begin
                  didx_r  <= 3'd0;
                  state_r <= S_DESC;
               end else begin
                  // Set wins: done over a clear, a new start over this stop
                  go_r[ch_r] <= apb_wr && wdec == {1'b1, 3'd5, 2'd0} && pwdata[ch_r];
                  done_r[ch_r] <= 1'b1;
                  state_r      <= S_IDLE;
               end
            S_DESC:
               if (pend_r) begin
                  if (mem_rvalid) begin
                     pend_r <= 1'b0;
                     didx_r <= didx_r + 3'd1;
                     case (didx_r[1:0])
                        2'd0:    mem_start_r[ch_r] <= mem_rdata;
                        2'd1:    pci_start_r[ch_r] <= mem_rdata;
                        2'd2:    count_r[ch_r]     <= mem_rdata;
                        default: link_r[ch_r]      <= mem_rdata;
                     endcase
                  end
               end else if (didx_r == `DMAC_DESC_WORDS) begin
                  state_r <= S_LOAD;
               end else begin
                  // Read on demand, so late edits to the descriptor are seen
                  pend_r   <= 1'b1;
                  mem_rd   <= 1'b1;
                  mem_addr <= link_r[ch_r] + {27'h0000000, didx_r, 2'b00};
               end
            default: state_r <= S_IDLE;
         endcase
         if (state_r == S_IDLE)
            pend_r <= 1'b0;
      end
   end

   // ==========================================================
   // Data path: FIFO then registered output stage
   dmac_fifo #(
      .WIDTH (64),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   ({cur_pci_r, mem_rdata}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   assign fifo_pop = fifo_out_valid & (~pci_valid | pci_ready);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pci_valid <= 1'b0;
         pci_addr  <= `DMAC_REG_RESET;
         pci_data  <= `DMAC_REG_RESET;
      end else if (~pci_valid | pci_ready) begin
         pci_valid <= fifo_out_valid;
         if (fifo_out_valid) begin
            pci_addr <= fifo_out_data[63:32];
            pci_data <= fifo_out_data[31:0];
         end
      end
   end
endmodule // dmac_chain

// ### hdl/dmac_defines.vh
// Constants for the DMA channel address and descriptor chaining block.
// Assumes inclusion by bare name from the design files.
`ifndef DMAC_DEFINES_VH
`define DMAC_DEFINES_VH

// ==========================================================
// Register byte offsets
`define DMAC_OFF_MEM_START_CH1  8'h3c
`define DMAC_OFF_MEM_START_CH2  8'h48
`define DMAC_OFF_MEM_START_CH3  8'ha8
`define DMAC_OFF_MEM_START_CH4  8'hb4
`define DMAC_OFF_PCI_START_CH1  8'h40
`define DMAC_OFF_PCI_START_CH2  8'h4c
`define DMAC_OFF_PCI_START_CH3  8'hac
`define DMAC_OFF_PCI_START_CH4  8'hb8
`define DMAC_OFF_LINK_CH1       8'hbc
`define DMAC_OFF_LINK_CH2       8'hc0
`define DMAC_OFF_LINK_CH3       8'hc4
`define DMAC_OFF_LINK_CH4       8'hc8
`define DMAC_OFF_WORDS_LEFT     8'h64
`define DMAC_OFF_CUR_MEM        8'h68
`define DMAC_OFF_CUR_PCI        8'h6c
`define DMAC_OFF_ARB            8'h80
`define DMAC_OFF_COUNT_CH1      8'hd0
`define DMAC_OFF_COUNT_CH2      8'hd4
`define DMAC_OFF_COUNT_CH3      8'hd8
`define DMAC_OFF_COUNT_CH4      8'hdc
`define DMAC_OFF_START          8'he0
`define DMAC_OFF_STATUS         8'he4

// ==========================================================
// Fields and reset values
`define DMAC_CHAIN_LSB          8
`define DMAC_CHAIN_MSB          11
`define DMAC_REG_RESET          32'h0000_0000
`define DMAC_DESC_WORDS         3'h4
`define DMAC_WORD_BYTES         32'h0000_0004

`endif

// ### tb/dmac_chain_properties.sv
// Port checker for the DMA chaining block, bound to dmac_chain.
// Assumes one clock domain and APB with exactly one wait state.
`timescale 1ns/10ps
// ==========
// Checker
module dmac_chain_props #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW    = 3
) (
   // APB
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Memory port
   input wire        mem_rd,
   input wire [31:0] mem_addr,
   input wire        mem_rvalid,
   input wire [31:0] mem_rdata,
   // PCI stream
   input wire        pci_valid,
   input wire        pci_ready,
   input wire [31:0] pci_addr,
   input wire [31:0] pci_data
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready not one cycle after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_idle_no_ready: assert property (!psel |=> !pready)
      else $error("pready without a transfer");
   a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data not zero on a write");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_mem_req_held: assert property (mem_rd && !mem_rvalid |=> mem_rd && $stable(mem_addr))
      else $error("memory request dropped or moved");
   a_mem_drop: assert property (mem_rvalid |=> !mem_rd)
      else $error("memory request held after answer");
   a_pci_held: assert property (pci_valid && !pci_ready |=>
      pci_valid && $stable(pci_addr) && $stable(pci_data))
      else $error("pci word changed before acceptance");
   a_reset_quiet: assert property ($rose(presetn) |-> !mem_rd && !pci_valid && !pready)
      else $error("outputs active after reset");

   c_pci_beat: cover property (pci_valid && pci_ready);
   c_mem_read: cover property (mem_rvalid);
   c_slverr: cover property (pslverr);
endmodule // dmac_chain_props

// ### tb/dmac_mem_model.sv
// Local memory model answering the block's read port with varying latency.
// Assumes one outstanding read, request held until the answer edge.
`timescale 1ns/10ps
// ==========
// Memory model
module dmac_mem_model (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // Read port
   input  wire        mem_rd,
   input  wire [31:0] mem_addr,
   output reg         mem_rvalid,
   output reg  [31:0] mem_rdata,
   // Statistics
   output int         n_reads
);
   logic [31:0] mem [0:1023];
   int          cnt;
   int          lat;

   initial begin
      for (int i = 0; i < 1024; i++)
         mem[i] = 32'hc0de_0000 | i;
   end

   // Data outside an answer keeps toggling so no stale word looks valid
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_rvalid <= 1'b0;
         mem_rdata  <= 32'h0;
         n_reads    <= 0;
         cnt        <= 0;
         lat        <= 1;
      end else if (mem_rd && !mem_rvalid && cnt == lat) begin
         mem_rvalid <= 1'b1;
         mem_rdata  <= mem[mem_addr[11:2]];
         n_reads    <= n_reads + 1;
         cnt        <= 0;
         lat        <= lat % 3 + 1;
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata  <= ~mem_rdata;
         cnt        <= (mem_rd && !mem_rvalid) ? cnt + 1 : 0;
      end
   end
endmodule // dmac_mem_model

// ### tb/dmac_chain_tb.sv
// Testbench for the DMA chaining block: APB tasks, memory model, PCI sink.
// Assumes one-wait-state APB timing and the memory-to-PCI direction.
`timescale 1ns/10ps
// ==========
// Bench
module dmac_chain_tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, pci_addr, pci_data, mem_addr, mem_rdata, rd;
   logic        pready, pslverr, mem_rd, mem_rvalid, pci_valid, err;
   logic        pci_ready = 0, hold = 0;
   logic [1:0]  cyc = 0;
   int          n_errors = 0, checked = 0, r0, n_reads;
   logic [31:0] qa[$], qd[$];
   logic [7:0]  offs[12] = '{8'h3c, 8'h48, 8'ha8, 8'hb4, 8'h40, 8'h4c, 8'hac, 8'hb8,
                            8'hbc, 8'hc0, 8'hc4, 8'hc8};
   logic [31:0] ea[5] = '{32'h2000, 32'h2004, 32'h3000, 32'h5000, 32'h5004};
   logic [31:0] es[5] = '{32'h100, 32'h104, 32'h200, 32'h280, 32'h284};

   dmac_chain u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .pci_valid(pci_valid), .pci_ready(pci_ready),
      .pci_addr(pci_addr), .pci_data(pci_data));
   dmac_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
      .n_reads(n_reads));

   initial begin
      forever #10 pclk = ~pclk;
   end

   // Sink stalls one cycle in four, or fully while hold is set
   always @(posedge pclk) begin
      cyc       <= cyc + 2'h1;
      pci_ready <= !hold && cyc != 2'h3;
      if (presetn && pci_valid === 1'b1 && pci_ready) begin
         qa.push_back(pci_addr);
         qd.push_back(pci_data);
      end
   end

   function automatic [31:0] expw(input [31:0] a);
      expw = 32'hc0de_0000 | {22'h0, a[11:2]};
   endfunction

   task test_done;
      $display("errors %0d checked %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input [31:0] g, input [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task chk_bit(input g, input e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task apb(input w, input [7:0] a, input [31:0] d);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 40);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_errors++;
         test_done;
      end
   endtask

   task wait_words(input int n);
      for (int i = 0; i < 3000 && qa.size() < n; i++)
         @(posedge pclk);
      if (qa.size() < n) begin
         n_errors++;
         test_done;
      end
      repeat (40) @(posedge pclk);
      chk(qa.size(), n);
   endtask

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         apb(0, offs[i], 0);
         chk(rd, 32'h0);
      end
      for (int i = 0; i < 12; i++)
         apb(1, offs[i], 32'h1357_0000 | offs[i]);
      for (int i = 0; i < 12; i++) begin
         apb(0, offs[i], 0);
         chk(rd, 32'h1357_0000 | offs[i]);
         chk_bit(err, 1'b0);
      end
      apb(1, 8'h10, 32'hffff_ffff);
      chk_bit(err, 1'b1);
      apb(0, 8'h10, 0);
      chk_bit(err, 1'b1);
      chk(rd, 32'h0);
      apb(1, 8'h80, 32'hffff_ffff);
      apb(0, 8'h80, 0);
      chk(rd, 32'h0000_0f00);
      // Chained channel 1: two descriptors, not adjacent
      u_mem.mem[10'h100] = 32'h200;
      u_mem.mem[10'h101] = 32'h3000;
      u_mem.mem[10'h102] = 32'h1;
      u_mem.mem[10'h103] = 32'h300;
      apb(1, 8'h3c, 32'h100);
      apb(1, 8'h40, 32'h2000);
      apb(1, 8'hd0, 32'h2);
      apb(1, 8'hbc, 32'h400);
      apb(1, 8'h80, 32'h100);
      apb(1, 8'he0, 32'h1);
      u_mem.mem[10'hc0] = 32'h280;
      u_mem.mem[10'hc1] = 32'h5000;
      u_mem.mem[10'hc2] = 32'h2;
      u_mem.mem[10'hc3] = 32'h0;
      wait_words(5);
      for (int i = 0; i < 5; i++) begin
         chk(qa[i], ea[i]);
         chk(qd[i], expw(es[i]));
      end
      chk(n_reads, 13);
      apb(0, 8'h3c, 0);
      chk(rd, 32'h280);
      apb(0, 8'hbc, 0);
      chk(rd, 32'h0);
      // Channel 2, chaining off, sink stalled until the FIFO refuses
      qa.delete();
      qd.delete();
      r0 = n_reads;
      hold <= 1'b1;
      apb(1, 8'h48, 32'h500);
      apb(1, 8'h4c, 32'h8000);
      apb(1, 8'hd4, 32'hc);
      apb(1, 8'hc0, 32'h600);
      apb(1, 8'h80, 32'h0);
      apb(1, 8'he0, 32'h2);
      repeat (200) @(posedge pclk);
      chk(n_reads - r0, 9);
      apb(0, 8'h64, 0);
      chk(rd, 32'h3);
      apb(0, 8'h68, 0);
      chk(rd, 32'h524);
      apb(0, 8'h6c, 0);
      chk(rd, 32'h8024);
      apb(0, 8'he4, 0);
      chk(rd, 32'h312);
      apb(1, 8'he4, 32'h10);
      apb(0, 8'he4, 0);
      chk(rd, 32'h302);
      apb(0, 8'h48, 0);
      chk(rd, 32'h500);
      apb(0, 8'h4c, 0);
      chk(rd, 32'h8000);
      apb(0, 8'hc0, 0);
      chk(rd, 32'h600);
      hold <= 1'b0;
      wait_words(12);
      for (int i = 0; i < 12; i++) begin
         chk(qa[i], 32'h8000 + 4 * i);
         chk(qd[i], expw(32'h500 + 4 * i));
      end
      chk(n_reads - r0, 12);
      apb(0, 8'he4, 0);
      chk(rd, 32'h220);
      test_done;
   end
endmodule // dmac_chain_tb

bind dmac_chain dmac_chain_props #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
   .pci_valid(pci_valid), .pci_ready(pci_ready), .pci_addr(pci_addr), .pci_data(pci_data));
